// ---- vrc_cmd_port.sv ----
// voice recorder serial command port: frame capture on the serial clock,
// command decode and record/playback/cueing sequencer on the system clock
// assumes the master idles the serial clock low and leaves select high at reset
`include "vrc_defines.svh"
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - select falling edge starts a frame
// - sample rising, shift falling, LSB first
// - eleven address bits then five control bits
// - marker or end of memory raises interrupt
// - next frame start clears pending interrupt
// - status shifts out while command shifts in
// - go bit starts, cleared go bit stops
// - execute only after select returns high
// - wake command powers up after settle delay
// - addressed listen plays from given row
// - resume listen plays on until marker
// - addressed capture records from given row
// - resume capture records until memory end
// - addressed skip cues from given row
// - resume skip cues to next marker
// - halt stops operation, stays powered
// - halt sleep stops and powers down
// - poll frame returns both status flags
// - cueing ignored while playback runs
// - control bits have fixed roles
// - last row marks end of memory
// - status carries current row pointer
// - cueing stops after marker, faster rows
// - cleared ignore bit repeats same row in listen and capture
module vrc_cmd_port #(
    parameter int unsigned SETTLE_CYCLES = `VRC_SETTLE_CYCLES,
    parameter int unsigned ROW_CYCLES = `VRC_ROW_CYCLES,
    parameter int unsigned CUE_ROW_CYCLES = `VRC_CUE_ROW_CYCLES
) (
    // system clock and reset
    input wire logic clk,
    input wire logic rst,
    // serial link
    input wire logic sclk,
    input wire logic ss_n,
    input wire logic mosi,
    output logic miso_out,
    output logic miso_oe_n,
    // storage array side
    input wire logic msg_end_in,
    // status
    output logic event_request_out,
    output logic power_ready,
    output logic play_active,
    output logic rec_active,
    output logic cue_active,
    output logic row_tick,
    output logic [`VRC_ROW_W-1:0] row_pointer_out
);

    localparam logic [`VRC_TIMER_W-1:0] SETTLE_LOAD = `VRC_TIMER_W'(SETTLE_CYCLES - 1);
    localparam logic [`VRC_TIMER_W-1:0] ROW_LOAD = `VRC_TIMER_W'(ROW_CYCLES - 1);
    localparam logic [`VRC_TIMER_W-1:0] CUE_LOAD = `VRC_TIMER_W'(CUE_ROW_CYCLES - 1);
    localparam logic [`VRC_CNT_W-1:0] FRAME_END = `VRC_CNT_W'(`VRC_FRAME_BITS);
    localparam logic [`VRC_CNT_W-1:0] LAST_BIT = `VRC_CNT_W'(`VRC_FRAME_BITS - 1);

    function automatic vrc_pkg::vrc_cmd_t vrc_decode(input logic [`VRC_CTL_W-1:0] c);
        vrc_pkg::vrc_cmd_t k;
        k = vrc_pkg::VRC_CMD_NONE;
        if ((c & `VRC_MASK_SLEEP) == `VRC_PAT_SLEEP) k = vrc_pkg::VRC_CMD_SLEEP;
        else if ((c & `VRC_MASK_HALT) == `VRC_PAT_HALT) k = vrc_pkg::VRC_CMD_HALT;
        else if (c == `VRC_PAT_WAKE) k = vrc_pkg::VRC_CMD_WAKE;
        else if (c == `VRC_PAT_ADDR_LISTEN) k = vrc_pkg::VRC_CMD_ADDR_LISTEN;
        else if (c == `VRC_PAT_RES_LISTEN) k = vrc_pkg::VRC_CMD_RES_LISTEN;
        else if (c == `VRC_PAT_ADDR_CAPTURE) k = vrc_pkg::VRC_CMD_ADDR_CAPTURE;
        else if (c == `VRC_PAT_RES_CAPTURE) k = vrc_pkg::VRC_CMD_RES_CAPTURE;
        else if (c == `VRC_PAT_ADDR_SKIP) k = vrc_pkg::VRC_CMD_ADDR_SKIP;
        else if (c == `VRC_PAT_RES_SKIP) k = vrc_pkg::VRC_CMD_RES_SKIP;
        return k;
    endfunction : vrc_decode

    // ---------------- serial clock domain ----------------
    vrc_pkg::vrc_link_t lnk;
    vrc_pkg::vrc_link_t next_lnk;
    logic [`VRC_CNT_W-1:0] cnt_in;
    logic [`VRC_CNT_W-1:0] cnt_out;
    logic frame_clr;

    vrc_pkg::vrc_core_t core;
    vrc_pkg::vrc_core_t next_core;

    // bit counters restart whenever select is high
    assign frame_clr = ss_n | rst;

    always_ff @(posedge sclk or posedge frame_clr) begin
        if (frame_clr) cnt_in <= '0;
        else if (cnt_in != FRAME_END) cnt_in <= cnt_in + 1'b1;
    end

    always_ff @(negedge sclk or posedge frame_clr) begin
        if (frame_clr) cnt_out <= '0;
        else if (cnt_out != FRAME_END) cnt_out <= cnt_out + 1'b1;
    end

    always_comb begin
        next_lnk = lnk;
        if (!ss_n) begin
            next_lnk.shreg = {mosi, lnk.shreg[`VRC_FRAME_BITS-1:1]};
            // the sixteenth bit completes a frame; shorter frames never toggle
            if (cnt_in == LAST_BIT) begin
                next_lnk.cmd = {mosi, lnk.shreg[`VRC_FRAME_BITS-1:1]};
                next_lnk.tgl = ~lnk.tgl;
            end
        end
    end

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) lnk <= '0;
        else lnk <= next_lnk;
    end

    // status snapshot is frozen while select is low
    assign miso_out = (cnt_out != FRAME_END) ? core.snap[cnt_out[3:0]] : 1'b0;
    assign miso_oe_n = ss_n;

    // ---------------- system clock domain ----------------
    logic [`VRC_CTL_W-1:0] ctl;
    logic [`VRC_ROW_W-1:0] addr;
    vrc_pkg::vrc_cmd_t kind;
    logic accept;
    logic frame_start;
    logic ev_eom;
    logic ev_ovf;

    // the command word is stable by the time its toggle is seen
    assign ctl = lnk.cmd[`VRC_FRAME_BITS-1:`VRC_CTL_POS];
    assign addr = lnk.cmd[`VRC_ROW_W-1:0];
    assign kind = vrc_decode(ctl);

    always_comb begin
        next_core = core;
        accept = 1'b0;
        frame_start = 1'b0;
        ev_eom = 1'b0;
        ev_ovf = 1'b0;
        next_core.row_tick = 1'b0;
        next_core.ss_sync = {core.ss_sync[1:0], ss_n};
        next_core.tgl_sync = {core.tgl_sync[1:0], lnk.tgl};
        if (core.ss_sync[2] == core.ss_sync[1]) next_core.ss_hi = core.ss_sync[2];
        frame_start = core.ss_hi && !next_core.ss_hi;
        // a finished frame runs only once select is back high
        accept = core.ss_hi && (core.tgl_sync[2] == core.tgl_sync[1])
            && (core.tgl_sync[2] != core.tgl_seen);

        // power sequencing
        if (core.pwr == vrc_pkg::VRC_PWR_SETTLE) begin
            if (core.timer == '0) next_core.pwr = vrc_pkg::VRC_PWR_READY;
            else next_core.timer = core.timer - 1'b1;
        end

        // running operation
        case (core.op)
            vrc_pkg::VRC_OP_IDLE: begin
            end
            vrc_pkg::VRC_OP_PLAY, vrc_pkg::VRC_OP_REC, vrc_pkg::VRC_OP_CUE: begin
                if (core.op != vrc_pkg::VRC_OP_REC && msg_end_in) begin
                    ev_eom = 1'b1;
                    next_core.op = vrc_pkg::VRC_OP_IDLE;
                    if (core.op == vrc_pkg::VRC_OP_CUE && core.row < `VRC_LAST_ROW)
                        next_core.row = core.row + 1'b1;
                end else if (core.timer == '0) begin
                    next_core.row_tick = 1'b1;
                    next_core.timer = (core.op == vrc_pkg::VRC_OP_CUE) ? CUE_LOAD : ROW_LOAD;
                    if (core.hold_row) begin
                        next_core.row = core.row;
                    end else if (core.row >= `VRC_LAST_ROW) begin
                        ev_ovf = 1'b1;
                        next_core.op = vrc_pkg::VRC_OP_IDLE;
                    end else begin
                        next_core.row = core.row + 1'b1;
                    end
                end else begin
                    next_core.timer = core.timer - 1'b1;
                end
            end
            default: next_core.op = vrc_pkg::VRC_OP_IDLE;
        endcase

        // new command
        if (accept) begin
            next_core.tgl_seen = core.tgl_sync[2];
            case (kind)
                vrc_pkg::VRC_CMD_SLEEP: begin
                    next_core.op = vrc_pkg::VRC_OP_IDLE;
                    next_core.pwr = vrc_pkg::VRC_PWR_OFF;
                end
                vrc_pkg::VRC_CMD_HALT: begin
                    next_core.op = vrc_pkg::VRC_OP_IDLE;
                end
                vrc_pkg::VRC_CMD_WAKE: begin
                    next_core.op = vrc_pkg::VRC_OP_IDLE;
                    if (core.pwr == vrc_pkg::VRC_PWR_OFF) begin
                        next_core.pwr = vrc_pkg::VRC_PWR_SETTLE;
                        next_core.timer = SETTLE_LOAD;
                    end
                end
                vrc_pkg::VRC_CMD_ADDR_LISTEN, vrc_pkg::VRC_CMD_ADDR_CAPTURE: begin
                    if (core.pwr == vrc_pkg::VRC_PWR_READY) begin
                        next_core.op = ctl[`VRC_DIR_BIT] ? vrc_pkg::VRC_OP_PLAY
                            : vrc_pkg::VRC_OP_REC;
                        next_core.row = addr;
                        next_core.hold_row = 1'b1;
                        next_core.timer = ROW_LOAD;
                    end
                end
                vrc_pkg::VRC_CMD_RES_LISTEN, vrc_pkg::VRC_CMD_RES_CAPTURE: begin
                    if (core.pwr == vrc_pkg::VRC_PWR_READY) begin
                        next_core.hold_row = 1'b0;
                        if (core.op != (ctl[`VRC_DIR_BIT] ? vrc_pkg::VRC_OP_PLAY
                            : vrc_pkg::VRC_OP_REC)) begin
                            next_core.op = ctl[`VRC_DIR_BIT] ? vrc_pkg::VRC_OP_PLAY
                                : vrc_pkg::VRC_OP_REC;
                            next_core.timer = ROW_LOAD;
                        end
                    end
                end
                vrc_pkg::VRC_CMD_ADDR_SKIP, vrc_pkg::VRC_CMD_RES_SKIP: begin
                    if (core.pwr == vrc_pkg::VRC_PWR_READY && core.op != vrc_pkg::VRC_OP_PLAY) begin
                        next_core.op = vrc_pkg::VRC_OP_CUE;
                        next_core.hold_row = 1'b0;
                        next_core.timer = CUE_LOAD;
                        if (!ctl[`VRC_IGNORE_BIT]) next_core.row = addr;
                    end
                end
                default: begin
                end
            endcase
        end

        // flags: a frame start clears them, a same-cycle event wins
        if (frame_start) begin
            next_core.irq = 1'b0;
            next_core.message_end_marker = 1'b0;
            next_core.ovf = 1'b0;
        end
        if (ev_eom) next_core.message_end_marker = 1'b1;
        if (ev_ovf) next_core.ovf = 1'b1;
        if (ev_eom || ev_ovf) next_core.irq = 1'b1;

        // snapshot follows live status only between frames
        if (core.ss_hi) begin
            next_core.snap = '0;
            next_core.snap[`VRC_ST_OVF] = core.ovf;
            next_core.snap[`VRC_ST_EOM] = core.message_end_marker;
            next_core.snap[`VRC_ST_ROW +: `VRC_ROW_W] = core.row;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            core <= '0;
            core.ss_sync <= 3'h7;
            core.ss_hi <= 1'b1;
            core.pwr <= vrc_pkg::VRC_PWR_OFF;
            core.op <= vrc_pkg::VRC_OP_IDLE;
        end else begin
            core <= next_core;
        end
    end

    assign event_request_out = core.irq;
    assign power_ready = (core.pwr == vrc_pkg::VRC_PWR_READY);
    assign play_active = (core.op == vrc_pkg::VRC_OP_PLAY);
    assign rec_active = (core.op == vrc_pkg::VRC_OP_REC);
    assign cue_active = (core.op == vrc_pkg::VRC_OP_CUE);
    assign row_tick = core.row_tick;
    assign row_pointer_out = core.row;

    // ---------------- checks ----------------
    // the cycle that sees select fall, with no end event beside it
    sequence s_sel_low;
        frame_start && !ev_eom && !ev_ovf;
    endsequence

    sequence s_event;
        ev_eom || ev_ovf;
    endsequence

    a_irq_on_event: assert property (@(posedge clk) disable iff (rst)
        s_event |=> core.irq && (core.message_end_marker || core.ovf))
        else $error("interrupt not raised after end event");

    a_irq_frame_clr: assert property (@(posedge clk) disable iff (rst)
        s_sel_low |=> !core.irq && !core.message_end_marker && !core.ovf)
        else $error("interrupt not cleared at frame start");

    a_snap_frozen: assert property (@(posedge clk) disable iff (rst)
        !$past(core.ss_hi) |-> $stable(core.snap))
        else $error("status snapshot moved during frame");

    a_settle_done: assert property (@(posedge clk) disable iff (rst)
        core.pwr == vrc_pkg::VRC_PWR_SETTLE && core.timer == '0 |=> power_ready)
        else $error("settle delay did not end in ready");

    a_exec_sel_high: assert property (@(posedge clk) disable iff (rst)
        $changed(core.tgl_seen) |-> $past(core.ss_hi) && $past(core.ss_sync[2]))
        else $error("command executed while select low");

    a_halt_stops: assert property (@(posedge clk) disable iff (rst)
        accept && kind == vrc_pkg::VRC_CMD_HALT |=> core.op == vrc_pkg::VRC_OP_IDLE
            && core.pwr == $past(core.pwr))
        else $error("halt did not stop operation");

    a_sleep_power: assert property (@(posedge clk) disable iff (rst)
        accept && kind == vrc_pkg::VRC_CMD_SLEEP |=> core.pwr == vrc_pkg::VRC_PWR_OFF
            ##1 !power_ready)
        else $error("sleep did not power down");

    a_wake_settle: assert property (@(posedge clk) disable iff (rst)
        accept && kind == vrc_pkg::VRC_CMD_WAKE && core.pwr == vrc_pkg::VRC_PWR_OFF
        |=> core.pwr == vrc_pkg::VRC_PWR_SETTLE && core.timer == SETTLE_LOAD)
        else $error("wake did not start settle delay");

    a_listen_row: assert property (@(posedge clk) disable iff (rst)
        accept && kind == vrc_pkg::VRC_CMD_ADDR_LISTEN && power_ready
        |=> play_active && core.row == $past(addr) && core.hold_row)
        else $error("addressed listen did not start at row");

    a_cue_in_play: assert property (@(posedge clk) disable iff (rst)
        accept && play_active && !msg_end_in && !(core.timer == '0)
            && (kind == vrc_pkg::VRC_CMD_ADDR_SKIP || kind == vrc_pkg::VRC_CMD_RES_SKIP)
        |=> play_active && core.row == $past(core.row))
        else $error("cueing disturbed running playback");

    a_ovf_last_row: assert property (@(posedge clk) disable iff (rst)
        !accept && core.op != vrc_pkg::VRC_OP_IDLE && core.timer == '0 && !core.hold_row
            && core.row == `VRC_LAST_ROW && !(msg_end_in && !rec_active)
        |=> core.ovf && core.op == vrc_pkg::VRC_OP_IDLE ##1 core.irq)
        else $error("end of memory not flagged at last row");

    a_cue_next_msg: assert property (@(posedge clk) disable iff (rst)
        !accept && cue_active && msg_end_in && core.row < `VRC_LAST_ROW
        |=> !cue_active && core.row == $past(core.row) + 1'b1 && core.message_end_marker)
        else $error("cueing did not step past marker");

endmodule : vrc_cmd_port

`default_nettype wire

// ---- vrc_cmd_port_tb_top.sv ----
// self-checking bench of the voice recorder serial command port
// assumes vrc_defines.svh on the include path and shortened timing parameters
`include "vrc_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module vrc_cmd_port_tb_top;
    localparam int SETTLE = 20;
    logic clk, rst, sclk, ss_n, mosi, miso_out, miso_oe_n, msg_end_in;
    logic event_request_out, power_ready, play_active, rec_active, cue_active, row_tick;
    logic [`VRC_ROW_W-1:0] row_pointer_out;
    logic [15:0] st;
    logic [`VRC_ROW_W-1:0] r;
    int failures, checked;

    vrc_cmd_port #(.SETTLE_CYCLES(SETTLE), .ROW_CYCLES(64), .CUE_ROW_CYCLES(4)) dut (
        .clk(clk), .rst(rst), .sclk(sclk), .ss_n(ss_n), .mosi(mosi),
        .miso_out(miso_out), .miso_oe_n(miso_oe_n), .msg_end_in(msg_end_in),
        .event_request_out(event_request_out), .power_ready(power_ready),
        .play_active(play_active), .rec_active(rec_active), .cue_active(cue_active),
        .row_tick(row_tick), .row_pointer_out(row_pointer_out));

    vrc_spi_master m (.sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso_out(miso_out),
        .miso_oe_n(miso_oe_n));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic chk1(input string what, input logic seen, input logic exp);
        check(what, {15'h0000, seen}, {15'h0000, exp});
    endtask : chk1

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : cyc

    task automatic send(input logic [4:0] ctl, input logic [10:0] row);
        m.frame({ctl, row}, 16, st);
        cyc(10);
    endtask : send

    task automatic wait_tick();
        int n;
        n = 0;
        while (row_tick !== 1'b1 && n < 200) begin
            cyc(1);
            n++;
        end
        chk1("row tick", row_tick, 1'b1);
        cyc(1);
    endtask : wait_tick

    task automatic wait_stop(input int lim);
        int n;
        n = 0;
        while ((play_active | rec_active | cue_active) !== 1'b0 && n < lim) begin
            cyc(1);
            n++;
        end
        chk1("stopped", play_active | rec_active | cue_active, 1'b0);
    endtask : wait_stop

    task automatic t_reset();
        chk1("irq", event_request_out, 1'b0);
        chk1("ready", power_ready, 1'b0);
        check("row", {5'h00, row_pointer_out}, 16'h0000);
        chk1("miso oe", miso_oe_n, 1'b1);
    endtask : t_reset

    task automatic t_wake();
        send(5'h1C, 11'h003);
        chk1("play asleep", play_active, 1'b0);
        send(5'h04, 11'h7FF);
        chk1("ready early", power_ready, 1'b0);
        cyc(SETTLE);
        chk1("ready", power_ready, 1'b1);
    endtask : t_wake

    task automatic t_play();
        send(5'h1C, 11'h005);
        chk1("play", play_active, 1'b1);
        check("start row", {5'h00, row_pointer_out}, 16'h0005);
        wait_tick();
        check("held row", {5'h00, row_pointer_out}, 16'h0005);
        send(5'h1E, 11'h000);
        r = row_pointer_out;
        wait_tick();
        check("next row", {5'h00, row_pointer_out}, {5'h00, r + 11'h001});
        send(5'h1D, 11'h009);
        chk1("cue ignored", cue_active, 1'b0);
        chk1("play kept", play_active, 1'b1);
        msg_end_in = 1'b1;
        cyc(3);
        msg_end_in = 1'b0;
        r = row_pointer_out;
        chk1("play ended", play_active, 1'b0);
        chk1("irq marker", event_request_out, 1'b1);
        send(5'h06, 11'h000);
        check("flags", {14'h0000, st[1:0]}, 16'h0002);
        check("pointer", {5'h00, st[12:2]}, {5'h00, r});
        check("pad", {13'h0000, st[15:13]}, 16'h0000);
        chk1("irq cleared", event_request_out, 1'b0);
        send(5'h06, 11'h000);
        check("flags cleared", {14'h0000, st[1:0]}, 16'h0000);
    endtask : t_play

    task automatic t_capture();
        send(5'h14, 11'h4AE);
        chk1("rec", rec_active, 1'b1);
        check("rec row", {5'h00, row_pointer_out}, 16'h04AE);
        send(5'h16, 11'h000);
        chk1("rec resumed", rec_active, 1'b1);
        wait_stop(300);
        check("last row", {5'h00, row_pointer_out}, 16'h04AF);
        chk1("irq overflow", event_request_out, 1'b1);
        send(5'h06, 11'h000);
        check("flags", {14'h0000, st[1:0]}, 16'h0001);
    endtask : t_capture

    task automatic t_short();
        m.frame({5'h14, 11'h010}, 8, st);
        cyc(10);
        chk1("short frame", rec_active, 1'b0);
        chk1("miso oe idle", miso_oe_n, 1'b1);
    endtask : t_short

    task automatic t_cue();
        msg_end_in = 1'b1;
        send(5'h1D, 11'h00A);
        msg_end_in = 1'b0;
        chk1("cue ended", cue_active, 1'b0);
        check("cue row", {5'h00, row_pointer_out}, 16'h000B);
        chk1("irq cue", event_request_out, 1'b1);
        m.frame({5'h1F, 11'h000}, 16, st);
        cyc(6);
        chk1("resume cue", cue_active, 1'b1);
        wait_stop(6000);
        check("cue end", {5'h00, row_pointer_out}, 16'h04AF);
        send(5'h06, 11'h000);
        check("flags", {14'h0000, st[1:0]}, 16'h0001);
    endtask : t_cue

    task automatic t_halt();
        send(5'h1C, 11'h014);
        chk1("play", play_active, 1'b1);
        send(5'h0E, 11'h000);
        chk1("halted", play_active, 1'b0);
        chk1("powered", power_ready, 1'b1);
        send(5'h1C, 11'h014);
        send(5'h02, 11'h000);
        chk1("sleep stop", play_active, 1'b0);
        chk1("asleep", power_ready, 1'b0);
        send(5'h1E, 11'h000);
        chk1("no start", play_active, 1'b0);
    endtask : t_halt

    task automatic wrap_up();
        if (failures == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up

    initial begin
        #3000000;
        failures++;
        wrap_up();
    end

    initial begin
        failures = 0;
        checked = 0;
        rst = 1'b1;
        msg_end_in = 1'b0;
        repeat (10) @(posedge clk);
        #2;
        rst = 1'b0;
        cyc(5);
        t_reset();
        t_wake();
        t_play();
        t_capture();
        t_short();
        t_cue();
        t_halt();
        wrap_up();
    end
endmodule : vrc_cmd_port_tb_top
`default_nettype wire

// ---- vrc_defines.svh ----
// constants of the voice recorder serial command port: frame layout, patterns, timing
// assumes inclusion by bare name from the package and the port module
`ifndef VRC_DEFINES_SVH
`define VRC_DEFINES_SVH

// frame layout
`define VRC_ROW_W 11
`define VRC_CTL_W 5
`define VRC_FRAME_BITS 16
`define VRC_CNT_W 5
`define VRC_CTL_POS 11

// control bit positions inside the control field
`define VRC_CUE_BIT 0
`define VRC_IGNORE_BIT 1
`define VRC_POWER_BIT 2
`define VRC_DIR_BIT 3
`define VRC_GO_BIT 4

// control patterns, control bit 0 in bit 0
`define VRC_PAT_WAKE 5'h04
`define VRC_PAT_ADDR_LISTEN 5'h1C
`define VRC_PAT_RES_LISTEN 5'h1E
`define VRC_PAT_ADDR_CAPTURE 5'h14
`define VRC_PAT_RES_CAPTURE 5'h16
`define VRC_PAT_ADDR_SKIP 5'h1D
`define VRC_PAT_RES_SKIP 5'h1F
`define VRC_MASK_HALT 5'h17
`define VRC_PAT_HALT 5'h06
`define VRC_MASK_SLEEP 5'h16
`define VRC_PAT_SLEEP 5'h02

// status word shifted out, bit 0 first
`define VRC_ST_OVF 0
`define VRC_ST_EOM 1
`define VRC_ST_ROW 2

// storage geometry
`define VRC_ROW_COUNT 1200
`define VRC_ROW_CELLS 1600
`define VRC_LAST_ROW 11'h4AF

// timing
`define VRC_CLK_MHZ 20
`define VRC_SAMPLE_HZ 8000
`define VRC_PUD_US 25000
`define VRC_ROW_US (`VRC_ROW_CELLS * 1000000 / `VRC_SAMPLE_HZ)
`define VRC_CUE_SPEEDUP 1600
`define VRC_SETTLE_CYCLES (`VRC_PUD_US * `VRC_CLK_MHZ)
`define VRC_ROW_CYCLES (`VRC_ROW_US * `VRC_CLK_MHZ)
`define VRC_CUE_ROW_CYCLES (`VRC_ROW_CYCLES / `VRC_CUE_SPEEDUP)
`define VRC_TIMER_W 23

`endif

// ---- vrc_pkg.sv ----
// types of the voice recorder serial command port
// assumes vrc_defines.svh is on the include path
`include "vrc_defines.svh"

package vrc_pkg;

    typedef enum logic [2:0] {
        VRC_PWR_OFF = 3'h1,
        VRC_PWR_SETTLE = 3'h2,
        VRC_PWR_READY = 3'h4
    } vrc_pwr_t;

    typedef enum logic [3:0] {
        VRC_OP_IDLE = 4'h1,
        VRC_OP_PLAY = 4'h2,
        VRC_OP_REC = 4'h4,
        VRC_OP_CUE = 4'h8
    } vrc_op_t;

    typedef enum logic [3:0] {
        VRC_CMD_NONE = 4'h0,
        VRC_CMD_WAKE = 4'h1,
        VRC_CMD_ADDR_LISTEN = 4'h2,
        VRC_CMD_RES_LISTEN = 4'h3,
        VRC_CMD_ADDR_CAPTURE = 4'h4,
        VRC_CMD_RES_CAPTURE = 4'h5,
        VRC_CMD_ADDR_SKIP = 4'h6,
        VRC_CMD_RES_SKIP = 4'h7,
        VRC_CMD_HALT = 4'h8,
        VRC_CMD_SLEEP = 4'h9
    } vrc_cmd_t;

    // state on the system clock
    typedef struct packed {
        logic [2:0] ss_sync;
        logic ss_hi;
        logic [2:0] tgl_sync;
        logic tgl_seen;
        vrc_pwr_t pwr;
        vrc_op_t op;
        logic [`VRC_ROW_W-1:0] row;
        logic hold_row;
        logic [`VRC_TIMER_W-1:0] timer;
        logic message_end_marker;
        logic ovf;
        logic irq;
        logic row_tick;
        logic [`VRC_FRAME_BITS-1:0] snap;
    } vrc_core_t;

    // state on the serial clock
    typedef struct packed {
        logic [`VRC_FRAME_BITS-1:0] shreg;
        logic [`VRC_FRAME_BITS-1:0] cmd;
        logic tgl;
    } vrc_link_t;

endpackage : vrc_pkg

// ---- vrc_spi_master.sv ----
// serial master model that shifts command frames into the command port
// assumes sclk idles low and frames are started by tasks of the bench top
`timescale 1ns/100ps
`default_nettype none
module vrc_spi_master (
    // link pins
    output logic sclk,
    output logic ss_n,
    output logic mosi,
    input wire logic miso_out,
    input wire logic miso_oe_n
);
    localparam int HALF = 80;

    initial begin
        sclk = 1'b0;
        ss_n = 1'b1;
        mosi = 1'b0;
    end

    // sends nbits of word lsb first, returns what came back on miso
    task automatic frame(input logic [15:0] word, input int nbits, output logic [15:0] status);
        status = 16'h0000;
        ss_n = 1'b0;
        #240;
        for (int i = 0; i < nbits; i++) begin
            mosi = word[i];
            #HALF;
            sclk = 1'b1;
            status[i] = miso_out;
            #HALF;
            sclk = 1'b0;
        end
        #HALF;
        ss_n = 1'b1;
        // released line shows the inverse of its last value
        mosi = ~mosi;
        #480;
    endtask : frame
endmodule : vrc_spi_master
`default_nettype wire
